// [core/timer16_wave_pkg.sv]
// shared constants and types for the 16-bit timer waveform control block
// assumes a 32-bit apb slave port and a timer core that supplies count state
package timer16_wave_pkg;

  // ==========================================================================
  // register map: register index, byte address is four times the index
  localparam logic [11:0] IDX_CTL_A = 12'h080;
  localparam logic [11:0] IDX_CTL_B = 12'h081;
  localparam logic [11:0] IDX_STATUS = 12'h083;
  localparam logic [11:0] ADDR_CTL_A = IDX_CTL_A << 2;
  localparam logic [11:0] ADDR_CTL_B = IDX_CTL_B << 2;
  localparam logic [11:0] ADDR_STATUS = IDX_STATUS << 2;

  // ==========================================================================
  // field layout
  localparam int ACT_A_LSB = 6;
  localparam int ACT_B_LSB = 4;
  localparam int MODE_LOW_LSB = 0;
  localparam int MODE_HIGH_LSB = 3;
  localparam logic [7:0] CTL_A_WRITE_MASK = 8'hf3;
  localparam logic [7:0] CTL_A_RESET = 8'h00;
  localparam logic [7:0] CTL_B_RESET = 8'h00;
  localparam int ST_WAVE_A_BIT = 0;
  localparam int ST_WAVE_B_BIT = 1;
  localparam int ST_OE_A_BIT = 2;
  localparam int ST_OE_B_BIT = 3;
  localparam int ST_MODE_LSB = 4;
  localparam int ST_TOP_LSB = 16;

  // ==========================================================================
  // counter limits
  localparam logic [15:0] BOTTOM = 16'h0000;
  localparam logic [15:0] TOP_MAX = 16'hffff;
  localparam logic [15:0] TOP_8BIT = 16'h00ff;
  localparam logic [15:0] TOP_9BIT = 16'h01ff;
  localparam logic [15:0] TOP_10BIT = 16'h03ff;

  // ==========================================================================
  // enumerations
  typedef enum logic [3:0] {
    mode_normal = 4'h0, mode_pc8 = 4'h1, mode_pc9 = 4'h2, mode_pc10 = 4'h3,
    mode_ctc_cmp = 4'h4, mode_fast8 = 4'h5, mode_fast9 = 4'h6, mode_fast10 = 4'h7,
    mode_pfc_cap = 4'h8, mode_pfc_cmp = 4'h9, mode_pc_cap = 4'ha, mode_pc_cmp = 4'hb,
    mode_ctc_cap = 4'hc, mode_reserved = 4'hd, mode_fast_cap = 4'he, mode_fast_cmp = 4'hf
  } mode_t;

  typedef enum logic [2:0] {
    kind_normal = 3'h0, kind_ctc = 3'h1, kind_fast = 3'h2,
    kind_phase = 3'h3, kind_phase_freq = 3'h4, kind_reserved = 3'h5
  } wave_kind_t;

  typedef enum logic [1:0] {
    pt_immediate = 2'h0, pt_top = 2'h1, pt_bottom = 2'h2, pt_max = 2'h3
  } event_point_t;

  typedef enum logic [1:0] {
    act_off = 2'b00, act_toggle = 2'b01, act_clear = 2'b10, act_set = 2'b11
  } action_t;

endpackage : timer16_wave_pkg

// [core/wave_mode_decode.sv]
// combinational decoder from the four-bit waveform mode to counting style
// assumes compare and capture values are the timer's live register values
`timescale 1ns/1ps
module wave_mode_decode (
  input wire timer16_wave_pkg::mode_t mode,
  input wire logic [15:0] compare_value_a,
  input wire logic [15:0] capture_value,
  output timer16_wave_pkg::wave_kind_t kind,
  output logic [15:0] top,
  output timer16_wave_pkg::event_point_t reload_at,
  output timer16_wave_pkg::event_point_t flag_at
);
  import timer16_wave_pkg::*;

  // ==========================================================================
  // mode table
  always_comb begin
    kind = kind_reserved;
    top = TOP_MAX;
    reload_at = pt_immediate;
    flag_at = pt_max;
    case (mode)
      mode_normal: begin
        kind = kind_normal;
      end
      mode_pc8, mode_pc9, mode_pc10, mode_pc_cap, mode_pc_cmp: begin
        kind = kind_phase;
        reload_at = pt_top;
        flag_at = pt_bottom;
        case (mode)
          mode_pc8: top = TOP_8BIT;
          mode_pc9: top = TOP_9BIT;
          mode_pc10: top = TOP_10BIT;
          mode_pc_cap: top = capture_value;
          default: top = compare_value_a;
        endcase
      end
      mode_ctc_cmp, mode_ctc_cap: begin
        kind = kind_ctc;
        top = (mode == mode_ctc_cmp) ? compare_value_a : capture_value;
      end
      mode_fast8, mode_fast9, mode_fast10, mode_fast_cap, mode_fast_cmp: begin
        kind = kind_fast;
        reload_at = pt_bottom;
        flag_at = pt_top;
        case (mode)
          mode_fast8: top = TOP_8BIT;
          mode_fast9: top = TOP_9BIT;
          mode_fast10: top = TOP_10BIT;
          mode_fast_cap: top = capture_value;
          default: top = compare_value_a;
        endcase
      end
      mode_pfc_cap, mode_pfc_cmp: begin
        kind = kind_phase_freq;
        reload_at = pt_bottom;
        flag_at = pt_bottom;
        top = (mode == mode_pfc_cap) ? capture_value : compare_value_a;
      end
      default: begin
        kind = kind_reserved;
      end
    endcase
  end

endmodule : wave_mode_decode

// [core/timer16_waveform_mode_ctl.sv]
// waveform mode control and compare output action logic, apb register slave
// assumes the timer core supplies counter, tick, direction and compare values
//
// Notes on behaviour
// - nonzero action field overrides pin function
// - pin driven only when direction is output
// - non-pwm actions: off, toggle, clear, set
// - fast pwm 10: clear match, set bottom
// - fast pwm 11: set match, clear bottom
// - fast toggle only channel a, modes 14/15
// - fast: compare equal top ignored except for toggle, bottom acts
// - dual slope 10: clear up, set down
// - dual slope 11: set up, clear down
// - dual toggle only channel a, modes 9/11
// - mode joins low and high two-bit fields
// - phase correct tops, reload top, flag bottom
// - phase-frequency correct: reload and flag bottom
// - control a at index 0x80 (byte address 0x200), resets zero
`timescale 1ns/1ps
module timer16_waveform_mode_ctl (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [15:0] counter_value,
  input wire logic count_tick,
  input wire logic count_down,
  input wire logic [15:0] compare_value_a,
  input wire logic [15:0] compare_value_b,
  input wire logic [15:0] capture_value,
  input wire logic port_dir_a,
  input wire logic port_dir_b,
  output logic wave_pin_a_override,
  output logic wave_pin_a_out,
  output logic wave_pin_a_oe,
  output logic wave_pin_b_override,
  output logic wave_pin_b_out,
  output logic wave_pin_b_oe,
  output logic [15:0] top_value,
  output logic dual_slope,
  output logic buffer_reload,
  output logic overflow_set
);
  import timer16_wave_pkg::*;

  typedef struct packed {
    logic [1:0] act_a;
    logic [1:0] act_b;
    logic [1:0] mode_low;
    logic [1:0] mode_high;
    logic wave_a;
    logic wave_b;
    logic oe_a;
    logic oe_b;
    logic [15:0] top;
    logic dual;
    logic ovf;
    logic reload;
    logic [31:0] rdata;
  } state_t;

  state_t s;
  state_t next_s;
  mode_t mode;
  wave_kind_t kind;
  logic [15:0] dec_top;
  event_point_t reload_at;
  event_point_t flag_at;
  logic match_a;
  logic match_b;
  logic at_bottom;
  logic at_top;
  logic toggle_ok_a;
  logic wr_en;
  logic mapped;

  // ==========================================================================
  // mode decode
  assign mode = mode_t'({s.mode_high, s.mode_low});

  wave_mode_decode u_decode (
    .mode(mode),
    .compare_value_a(compare_value_a),
    .capture_value(capture_value),
    .kind(kind),
    .top(dec_top),
    .reload_at(reload_at),
    .flag_at(flag_at)
  );

  // ==========================================================================
  // per-channel output action
  function automatic logic next_wave(input logic cur, input action_t act, input wave_kind_t k,
                                     input logic toggle_ok, input logic match, input logic bottom,
                                     input logic down, input logic cmp_is_top);
    logic r;
    r = cur;
    case (k)
      kind_normal, kind_ctc: begin
        if (match) begin
          case (act)
            act_toggle: r = ~cur;
            act_clear: r = 1'b0;
            act_set: r = 1'b1;
            default: r = cur;
          endcase
        end
      end
      kind_fast: begin
        if (bottom && act[1]) begin
          r = (act == act_clear);
        end
        if (match && act[1] && !cmp_is_top) begin
          r = (act == act_set);
        end else if (match && act == act_toggle && toggle_ok) begin
          r = ~cur;
        end
      end
      kind_phase, kind_phase_freq: begin
        if (match && act[1]) begin
          r = (act == act_set) ^ down;
        end else if (match && act == act_toggle && toggle_ok) begin
          r = ~cur;
        end
      end
      default: r = cur;
    endcase
    return r;
  endfunction : next_wave

  function automatic logic point_hit(input event_point_t pt, input logic top_hit,
                                     input logic bottom_hit, input logic max_hit);
    case (pt)
      pt_immediate: return 1'b1;
      pt_top: return top_hit;
      pt_bottom: return bottom_hit;
      default: return max_hit;
    endcase
  endfunction : point_hit

  function automatic logic dual_slope_now(input wave_kind_t k);
    return (k == kind_phase) || (k == kind_phase_freq);
  endfunction : dual_slope_now

  assign match_a = count_tick && (counter_value == compare_value_a);
  assign match_b = count_tick && (counter_value == compare_value_b);
  assign at_bottom = count_tick && (counter_value == BOTTOM);
  assign at_top = count_tick && (counter_value == dec_top);
  assign toggle_ok_a = (kind == kind_fast) ? (mode == mode_fast_cap || mode == mode_fast_cmp) :
                       (mode == mode_pfc_cmp || mode == mode_pc_cmp) ||
                       (kind == kind_normal || kind == kind_ctc);

  // ==========================================================================
  // apb access
  assign pready = penable;
  assign mapped = (paddr == ADDR_CTL_A) || (paddr == ADDR_CTL_B) || (paddr == ADDR_STATUS);
  assign pslverr = psel && penable && !mapped;
  assign wr_en = psel && penable && pwrite && pstrb[0] && mapped;
  assign prdata = s.rdata;

  // ==========================================================================
  // next state
  always_comb begin
    next_s = s;
    if (wr_en && paddr == ADDR_CTL_A) begin
      next_s.act_a = pwdata[ACT_A_LSB +: 2];
      next_s.act_b = pwdata[ACT_B_LSB +: 2];
      next_s.mode_low = pwdata[MODE_LOW_LSB +: 2];
    end
    if (wr_en && paddr == ADDR_CTL_B) begin
      next_s.mode_high = pwdata[MODE_HIGH_LSB +: 2];
    end
    next_s.rdata = '0;
    if (psel && !penable && !pwrite) begin
      case (paddr)
        ADDR_CTL_A: begin
          next_s.rdata[7:0] = {s.act_a, s.act_b, 2'b00, s.mode_low} & CTL_A_WRITE_MASK;
        end
        ADDR_CTL_B: next_s.rdata[MODE_HIGH_LSB +: 2] = s.mode_high;
        ADDR_STATUS: begin
          next_s.rdata[ST_WAVE_A_BIT] = s.wave_a;
          next_s.rdata[ST_WAVE_B_BIT] = s.wave_b;
          next_s.rdata[ST_OE_A_BIT] = s.oe_a;
          next_s.rdata[ST_OE_B_BIT] = s.oe_b;
          next_s.rdata[ST_MODE_LSB +: 4] = mode;
          next_s.rdata[ST_TOP_LSB +: 16] = s.top;
        end
        default: next_s.rdata = '0;
      endcase
    end
    next_s.wave_a = next_wave(s.wave_a, action_t'(s.act_a), kind, toggle_ok_a, match_a, at_bottom,
                              count_down, compare_value_a == dec_top);
    next_s.wave_b = next_wave(s.wave_b, action_t'(s.act_b), kind, 1'b0, match_b, at_bottom,
                              count_down, compare_value_b == dec_top);
    if (kind == kind_normal || kind == kind_ctc) begin
      next_s.wave_b = next_wave(s.wave_b, action_t'(s.act_b), kind, 1'b1, match_b, at_bottom,
                                count_down, compare_value_b == dec_top);
    end
    next_s.oe_a = port_dir_a && (s.act_a != act_off);
    next_s.oe_b = port_dir_b && (s.act_b != act_off);
    next_s.top = dec_top;
    next_s.dual = dual_slope_now(kind);
    next_s.reload = count_tick && point_hit(reload_at, at_top, at_bottom, counter_value == TOP_MAX);
    next_s.ovf = count_tick && (kind != kind_reserved) &&
                 point_hit(flag_at, at_top, at_bottom, counter_value == TOP_MAX);
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // ==========================================================================
  // pin and timer outputs
  assign wave_pin_a_override = (s.act_a != act_off);
  assign wave_pin_b_override = (s.act_b != act_off);
  assign wave_pin_a_out = s.wave_a;
  assign wave_pin_b_out = s.wave_b;
  assign wave_pin_a_oe = s.oe_a;
  assign wave_pin_b_oe = s.oe_b;
  assign top_value = s.top;
  assign dual_slope = s.dual;
  assign buffer_reload = s.reload;
  assign overflow_set = s.ovf;

  // ==========================================================================
  // assertions
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  override_gate_a: assert property ((wr_en && paddr == ADDR_CTL_A)
    |=> wave_pin_a_override == $past(pwdata[ACT_A_LSB +: 2] != 2'b00))
    else $error("override does not follow action field");
  oe_dir_gate_a: assert property (##1 wave_pin_a_oe == $past(port_dir_a && s.act_a != 2'b00))
    else $error("pin a driver enable wrong");
  oe_dir_gate_b: assert property (##1 wave_pin_b_oe == $past(port_dir_b && s.act_b != 2'b00))
    else $error("pin b driver enable wrong");
  normal_toggle_a: assert property ((kind == kind_normal && s.act_a == act_toggle && match_a)
    |=> wave_pin_a_out != $past(wave_pin_a_out))
    else $error("normal mode toggle missed");
  nonpwm_clear_b: assert property (((kind == kind_normal || kind == kind_ctc) && s.act_b == act_clear
    && match_b) |=> !wave_pin_b_out)
    else $error("channel b clear on match missed");
  fast_clear_a: assert property ((kind == kind_fast && s.act_a == act_clear && match_a &&
    compare_value_a != dec_top) |=> !wave_pin_a_out)
    else $error("fast pwm clear on match missed");
  fast_set_bottom_a: assert property ((kind == kind_fast && s.act_a == act_clear && at_bottom && !match_a)
    |=> wave_pin_a_out)
    else $error("non-inverting fast pwm bottom set missed");
  fast_inv_bottom_a: assert property ((kind == kind_fast && s.act_a == act_set && at_bottom && !match_a)
    |=> !wave_pin_a_out)
    else $error("inverting fast pwm bottom clear missed");
  fast_chan_b_a: assert property ((kind == kind_fast && s.act_b == act_toggle)
    |=> wave_pin_b_out == $past(wave_pin_b_out))
    else $error("channel b toggled in fast pwm");
  fast_toggle_a: assert property ((mode == mode_fast_cmp && s.act_a == act_toggle && match_a)
    |=> wave_pin_a_out != $past(wave_pin_a_out))
    else $error("fast pwm channel a toggle missed");
  fast_top_ignore_a: assert property ((kind == kind_fast && s.act_a == act_clear && match_a &&
    compare_value_a == dec_top && !at_bottom) |=> wave_pin_a_out == $past(wave_pin_a_out))
    else $error("match at top not ignored");
  dual_down_set_a: assert property ((dual_slope_now(kind) && s.act_a == act_clear && match_a && count_down)
    |=> wave_pin_a_out)
    else $error("dual slope down match did not set");
  dual_up_clear_a: assert property ((dual_slope_now(kind) && s.act_a == act_clear && match_a && !count_down)
    |=> !wave_pin_a_out)
    else $error("dual slope up match did not clear");
  dual_up_set_a: assert property ((dual_slope_now(kind) && s.act_a == act_set && match_a && !count_down)
    |=> wave_pin_a_out)
    else $error("dual slope up match did not set");
  dual_toggle_off_a: assert property ((mode == mode_pc8 && s.act_a == act_toggle)
    |=> wave_pin_a_out == $past(wave_pin_a_out))
    else $error("channel a toggled in 8-bit phase correct mode");
  mode_high_wr_a: assert property ((wr_en && paddr == ADDR_CTL_B)
    |=> mode[3:2] == $past(pwdata[MODE_HIGH_LSB +: 2]))
    else $error("upper mode bits not written");
  pc8_top_a: assert property ((mode == mode_pc8) |=> top_value == TOP_8BIT)
    else $error("phase correct 8-bit top wrong");
  pc_reload_top_a: assert property ((kind == kind_phase && at_top) |=> buffer_reload)
    else $error("phase correct reload at top missing");
  pfc_bottom_a: assert property ((kind == kind_phase_freq && at_bottom) |=> buffer_reload && overflow_set)
    else $error("phase-frequency bottom events missing");
  ro_bits_a: assert property ((psel && !penable && !pwrite && paddr == ADDR_CTL_A) |=> prdata[3:2] == 2'b00)
    else $error("read-only bits not zero");
  reserved_flag_a: assert property ((mode == mode_reserved) |=> !overflow_set)
    else $error("reserved mode raised overflow");

  fast_pwm_c: cover property (kind == kind_fast && s.act_a == act_clear && at_bottom);
  dual_match_c: cover property (dual_slope_now(kind) && match_b && s.act_b == act_set);
  apb_write_c: cover property (wr_en && paddr == ADDR_CTL_B);
  pc_toggle_c: cover property (mode == mode_pc_cmp && s.act_a == act_toggle && match_a);
  reload_flag_c: cover property (buffer_reload && overflow_set);

endmodule : timer16_waveform_mode_ctl

// [verif/test_timer16_waveform_mode_ctl.sv]
// self-checking testbench for the waveform mode control block
// assumes timer16_wave_pkg and the design modules are compiled first; the bench drives apb and timer inputs
`timescale 1ns/1ps
module test_timer16_waveform_mode_ctl;
  import timer16_wave_pkg::*;

  // ==========================================================================
  // stimulus signals and design
  logic ref_clk = 1'b0;
  logic nrst = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'h0;
  logic [31:0] prdata;
  logic pready, pslverr;
  logic [15:0] counter_value = 16'h0000;
  logic [15:0] cmp_a = 16'h0040;
  logic [15:0] cmp_b = 16'h0040;
  logic [15:0] capture_value = 16'h1234;
  logic count_tick = 1'b0;
  logic count_down = 1'b0;
  logic port_dir_a = 1'b1;
  logic port_dir_b = 1'b0;
  logic ov_a, out_a, oe_a, ov_b, out_b, oe_b, dual_slope, buffer_reload, overflow_set;
  logic [15:0] top_value;
  logic [31:0] rd;
  logic err, seen_ovf, seen_rel;
  int fails = 0;
  int tests_run = 0;
  int cycles = 0;
  // mode, counter, overflow pulse, reload pulse, reload checked
  localparam logic [22:0] PULSES [10] = '{{4'h0, 16'hffff, 3'b111}, {4'h0, 16'h0040, 3'b011},
    {4'h1, 16'h0000, 3'b101}, {4'h1, 16'h00ff, 3'b011}, {4'h5, 16'h00ff, 3'b101}, {4'h5, 16'h0000, 3'b011},
    {4'h9, 16'h0000, 3'b111}, {4'h9, 16'h0040, 3'b001}, {4'hd, 16'hffff, 3'b000}, {4'hd, 16'h0000, 3'b000}};

  timer16_waveform_mode_ctl u_timer16_waveform_mode_ctl (
    .ref_clk(ref_clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .counter_value(counter_value), .count_tick(count_tick), .count_down(count_down),
    .compare_value_a(cmp_a), .compare_value_b(cmp_b), .capture_value(capture_value),
    .port_dir_a(port_dir_a), .port_dir_b(port_dir_b), .wave_pin_a_override(ov_a), .wave_pin_a_out(out_a),
    .wave_pin_a_oe(oe_a), .wave_pin_b_override(ov_b), .wave_pin_b_out(out_b), .wave_pin_b_oe(oe_b),
    .top_value(top_value), .dual_slope(dual_slope), .buffer_reload(buffer_reload), .overflow_set(overflow_set)
  );

  always #2.5 ref_clk = ~ref_clk;

  // ==========================================================================
  // tasks
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : end_of_test

  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fails++;
      end_of_test();
    end
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic set_mode(input logic [3:0] m, input logic [1:0] aa, input logic [1:0] ab);
    apb(1'b1, ADDR_CTL_A, {24'h0, aa, ab, 2'b00, m[1:0]}, 4'h1);
    apb(1'b1, ADDR_CTL_B, {27'h0, m[3:2], 3'b000}, 4'h1);
  endtask : set_mode

  task automatic tick(input logic [15:0] c, input logic d);
    @(posedge ref_clk);
    counter_value <= c;
    count_down <= d;
    count_tick <= 1'b1;
    @(posedge ref_clk);
    count_tick <= 1'b0;
    #1;
    seen_ovf = overflow_set;
    seen_rel = buffer_reload;
  endtask : tick

  task automatic waves(input logic ea, input logic eb);
    check("wave a", out_a, ea);
    check("wave b", out_b, eb);
  endtask : waves

  task automatic test_done(input string n);
    $display("test %s finished", n);
  endtask : test_done

  function automatic logic [15:0] top_of(input int m);
    case (m)
      0, 13: top_of = TOP_MAX;
      1, 5: top_of = TOP_8BIT;
      2, 6: top_of = TOP_9BIT;
      3, 7: top_of = TOP_10BIT;
      4, 9, 11, 15: top_of = cmp_a;
      default: top_of = capture_value;
    endcase
  endfunction : top_of

  // ==========================================================================
  // main sequence
  initial begin
    repeat (2) @(posedge ref_clk);
    nrst <= 1'b1;
    apb(1'b0, ADDR_CTL_A, 32'h0, 4'h0);
    check("ctl_a reset", rd, 32'h0);
    apb(1'b1, ADDR_CTL_A, 32'hff, 4'h0);
    apb(1'b0, ADDR_CTL_A, 32'h0, 4'h0);
    check("ctl_a no strobe", rd, 32'h0);
    apb(1'b1, ADDR_CTL_A, 32'hff, 4'h1);
    apb(1'b0, ADDR_CTL_A, 32'h0, 4'h0);
    check("ctl_a read only", rd, 32'hf3);
    apb(1'b0, 12'h0fc, 32'h0, 4'h0);
    check("unmapped err", err, 1'b1);
    check("unmapped data", rd, 32'h0);
    test_done("registers");
    for (int m = 0; m < 16; m++) begin
      set_mode(m[3:0], 2'b00, 2'b00);
      apb(1'b0, ADDR_STATUS, 32'h0, 4'h0);
      check("mode", rd[7:4], m[3:0]);
      check("status top", rd[31:16], top_of(m));
      check("top port", top_value, top_of(m));
      check("dual slope", dual_slope, m inside {1, 2, 3, 8, 9, 10, 11});
    end
    test_done("mode decode");
    set_mode(4'h0, 2'b11, 2'b10);
    @(posedge ref_clk);
    #1;
    check("override a", ov_a, 1'b1);
    check("override b", ov_b, 1'b1);
    check("enable a", oe_a, 1'b1);
    check("enable b", oe_b, 1'b0);
    @(posedge ref_clk);
    port_dir_a <= 1'b0;
    port_dir_b <= 1'b1;
    repeat (2) @(posedge ref_clk);
    #1;
    check("override dir in", ov_a, 1'b1);
    check("enable a dir in", oe_a, 1'b0);
    check("enable b dir out", oe_b, 1'b1);
    @(posedge ref_clk);
    port_dir_a <= 1'b1;
    port_dir_b <= 1'b0;
    tick(16'h0040, 1'b0);
    waves(1'b1, 1'b0);
    apb(1'b0, ADDR_STATUS, 32'h0, 4'h0);
    check("status pins", rd[3:0], 4'b0101);
    set_mode(4'h0, 2'b01, 2'b11);
    tick(16'h0040, 1'b0);
    waves(1'b0, 1'b1);
    tick(16'h0040, 1'b0);
    waves(1'b1, 1'b1);
    set_mode(4'h0, 2'b00, 2'b00);
    @(posedge ref_clk);
    #1;
    check("override off", ov_a, 1'b0);
    check("enable off", oe_a, 1'b0);
    tick(16'h0040, 1'b0);
    waves(1'b1, 1'b1);
    test_done("non pwm actions");
    set_mode(4'h5, 2'b10, 2'b11);
    tick(16'h0000, 1'b0);
    waves(1'b1, 1'b0);
    tick(16'h0040, 1'b0);
    waves(1'b0, 1'b1);
    @(posedge ref_clk);
    cmp_a <= 16'h00ff;
    tick(16'h0000, 1'b0);
    tick(16'h00ff, 1'b0);
    waves(1'b1, 1'b0);
    @(posedge ref_clk);
    cmp_a <= 16'h0040;
    set_mode(4'h5, 2'b01, 2'b01);
    tick(16'h0040, 1'b0);
    waves(1'b1, 1'b0);
    set_mode(4'hf, 2'b01, 2'b01);
    tick(16'h0040, 1'b0);
    waves(1'b0, 1'b0);
    test_done("fast pwm");
    set_mode(4'h1, 2'b10, 2'b11);
    tick(16'h0040, 1'b0);
    waves(1'b0, 1'b1);
    tick(16'h0040, 1'b1);
    waves(1'b1, 1'b0);
    tick(16'h0040, 1'b0);
    waves(1'b0, 1'b1);
    set_mode(4'h1, 2'b01, 2'b01);
    tick(16'h0040, 1'b0);
    waves(1'b0, 1'b1);
    set_mode(4'hb, 2'b01, 2'b01);
    tick(16'h0040, 1'b0);
    waves(1'b1, 1'b1);
    test_done("dual slope");
    foreach (PULSES[i]) begin
      set_mode(PULSES[i][22:19], 2'b00, 2'b00);
      tick(PULSES[i][18:3], 1'b0);
      check("overflow pulse", seen_ovf, PULSES[i][2]);
      if (PULSES[i][0]) begin
        check("reload pulse", seen_rel, PULSES[i][1]);
      end
    end
    test_done("event points");
    end_of_test();
  end

endmodule : test_timer16_waveform_mode_ctl
